/* rtl/cpdo_core.sv */
// PDO trigger, SYNC and EMCY protocol logic with an APB register file
// *****************************************************************
// Overview of operation
// - Type 0 TPDO: send on SYNC if changed
// - Types 1-240: send every N-th SYNC
// - Types 254/255: send on change or timer
// - Sync RPDO: newest data released on SYNC
// - Async RPDO: data released on reception
// - SYNC id bit 30 enables production, id 0x80
// - Drive is SYNC producer or consumer
// - Synchronous commands buffered until next SYNC
// - Produce EMCY only, ignore received EMCY
// - Faults update error registers even if disabled
// - EMCY bit 31 gates; id 0x80+node
// - EMCY bytes: code, errreg, unused, aux
// - Communication faults carry zero aux bytes
// - User exception sends 0xff00 with aux
// - Mapping: count plus index/subindex/length entries
// - Id bit 31 set disables the PDO
// - Inhibit time in 125 us between sends
// - Mapping over 8 bytes is rejected
// *****************************************************************
`timescale 1ns/10ps
module cpdo_core import cpdo_pkg::*; (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rx_valid,
    input  wire cpdo_frame_s       rx_frame,
    output logic                   tx_valid,
    output cpdo_frame_s            tx_frame,
    input  wire logic              tx_ready,
    input  wire logic [3:0][31:0]  tpdo_obj,
    output logic      [63:0]       rpdo_data,
    output logic                   rpdo_valid,
    output logic                   sync_pulse,
    input  wire logic              fault_valid,
    input  wire cpdo_fault_s       fault
);
    // *************************************************************
    // Registers
    // *************************************************************
    logic [6:0]       node_id;
    logic [31:0]      sync_id;
    logic [31:0]      sync_per;
    logic [31:0]      emcy_id;
    logic [31:0]      tpdo_id;
    logic [7:0]       tpdo_type;
    logic [15:0]      tpdo_inh;
    logic [15:0]      tpdo_evt;
    logic [2:0]       map_cnt;
    logic [3:0][31:0] map_ent;
    logic [31:0]      rpdo_id;
    logic [7:0]       rpdo_type;
    logic [7:0]       err_reg;
    logic [15:0]      err_code;
    logic [7:0]       err_count;
    logic             rpdo_hold_v;
    logic             tpdo_pend;

    logic             wr_en;
    logic             setup;
    logic             map_wr;
    logic [2:0]       next_cnt;
    logic [3:0][31:0] next_ent;
    logic             map_ok;
    logic             hit;
    logic [31:0]      rd_val;

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite && pready && !pslverr;
    assign map_wr = paddr >= OFS_TPDO_MCNT && paddr <= OFS_TPDO_MAP0 + 8'h0c;

    // Candidate mapping as it would be after the write
    always_comb begin
        next_cnt = map_cnt;
        next_ent = map_ent;
        if (paddr == OFS_TPDO_MCNT) begin
            next_cnt = pwdata[2:0];
        end else if (map_wr) begin
            next_ent[paddr[3:2] - 2'h1] = pwdata;
        end
    end

    // Length check of a candidate mapping
    always_comb begin
        logic [7:0] total;
        total  = 8'h00;
        map_ok = (next_cnt <= 3'h4);
        // Entry written beyond the count is still length checked
        if (map_wr && paddr != OFS_TPDO_MCNT && pwdata[7:0] != 8'h08
            && pwdata[7:0] != 8'h10 && pwdata[7:0] != 8'h20) begin
            map_ok = 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < next_cnt) begin
                if (next_ent[i][7:0] != 8'h08 && next_ent[i][7:0] != 8'h10
                    && next_ent[i][7:0] != 8'h20) begin
                    map_ok = 1'b0;
                end
                total = total + next_ent[i][7:0];
            end
        end
        if (total > {1'b0, MAX_BITS}) begin
            map_ok = 1'b0;
        end
    end

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            OFS_NODE_ID:   rd_val = {25'h0, node_id};
            OFS_SYNC_ID:   rd_val = sync_id;
            OFS_SYNC_PER:  rd_val = sync_per;
            OFS_EMCY_ID:   rd_val = emcy_id;
            OFS_TPDO_ID:   rd_val = tpdo_id;
            OFS_TPDO_TYPE: rd_val = {24'h0, tpdo_type};
            OFS_TPDO_INH:  rd_val = {16'h0, tpdo_inh};
            OFS_TPDO_EVT:  rd_val = {16'h0, tpdo_evt};
            OFS_TPDO_MCNT: rd_val = {29'h0, map_cnt};
            8'h24, 8'h28, 8'h2c, 8'h30:
                           rd_val = map_ent[paddr[3:2] - 2'h1];
            OFS_RPDO_ID:   rd_val = rpdo_id;
            OFS_RPDO_TYPE: rd_val = {24'h0, rpdo_type};
            OFS_ERR_REG:   rd_val = {24'h0, err_reg};
            OFS_ERR_FIELD: rd_val = {8'h0, err_count, err_code};
            OFS_STATUS:    rd_val = {29'h0, tx_valid, rpdo_hold_v,
                                     tpdo_pend};
            default:       hit = 1'b0;
        endcase
    end

    // *************************************************************
    // APB answer, sampled in the setup cycle
    // *************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= !hit || (pwrite && map_wr && !map_ok);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_id   <= 7'h00;
            sync_id   <= RST_SYNC_ID;
            sync_per  <= 32'h0000_0000;
            emcy_id   <= RST_EMCY_ID;
            tpdo_id   <= RST_TPDO_ID;
            tpdo_type <= 8'h00;
            tpdo_inh  <= 16'h0000;
            tpdo_evt  <= 16'h0000;
            map_cnt   <= 3'h0;
            map_ent   <= '0;
            rpdo_id   <= RST_RPDO_ID;
            rpdo_type <= 8'h00;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_NODE_ID:   node_id   <= pwdata[6:0];
                OFS_SYNC_ID:   sync_id   <= pwdata;
                OFS_SYNC_PER:  sync_per  <= pwdata;
                OFS_EMCY_ID:   emcy_id   <= pwdata;
                OFS_TPDO_ID:   tpdo_id   <= pwdata;
                OFS_TPDO_TYPE: tpdo_type <= pwdata[7:0];
                OFS_TPDO_INH:  tpdo_inh  <= pwdata[15:0];
                OFS_TPDO_EVT:  tpdo_evt  <= pwdata[15:0];
                OFS_RPDO_ID:   rpdo_id   <= pwdata;
                OFS_RPDO_TYPE: rpdo_type <= pwdata[7:0];
                default: begin
                    if (map_wr) begin
                        map_cnt <= next_cnt;
                        map_ent <= next_ent;
                    end
                end
            endcase
        end
    end

    // *************************************************************
    // Time base and SYNC
    // *************************************************************
    logic [5:0]  us_div;
    logic        us_tick;
    logic [31:0] per_cnt;
    logic        sync_gen;
    logic        sync_rx;
    logic        sync_due;
    logic        sync_evt;
    logic        tx_done;
    cpdo_kind_e  tx_kind;

    assign us_tick  = (us_div == 6'(US_CYC - 1));
    assign sync_gen = sync_id[BIT_SYNC_GEN];
    // A producer never consumes foreign SYNC frames
    assign sync_rx  = rx_valid && !sync_gen
                      && rx_frame.id == sync_id[10:0];
    assign tx_done  = tx_valid && tx_ready;
    assign sync_evt = sync_rx
                      || (tx_done && tx_kind == K_SYNC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_div <= 6'h00;
        end else begin
            us_div <= us_tick ? 6'h00 : us_div + 6'h01;
        end
    end

    // Producer period in microseconds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt  <= 32'h0000_0000;
            sync_due <= 1'b0;
        end else begin
            if (!sync_gen || sync_per == 32'h0) begin
                per_cnt <= 32'h0000_0000;
            end else if (us_tick) begin
                per_cnt <= (per_cnt + 32'h1 >= sync_per) ? 32'h0
                                                         : per_cnt + 32'h1;
            end
            if (sync_gen && sync_per != 32'h0 && us_tick
                && per_cnt + 32'h1 >= sync_per) begin
                sync_due <= 1'b1;
            end else if (tx_done && tx_kind == K_SYNC) begin
                sync_due <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_pulse <= 1'b0;
        end else begin
            sync_pulse <= sync_evt;
        end
    end

    // *************************************************************
    // Receive PDO
    // *************************************************************
    logic [63:0] rpdo_hold;
    logic        rpdo_rx;

    assign rpdo_rx = rx_valid && !rpdo_id[BIT_INVALID]
                     && rx_frame.id == rpdo_id[10:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpdo_hold   <= 64'h0;
            rpdo_hold_v <= 1'b0;
        end else if (rpdo_rx && rpdo_type <= TYPE_CYC_MAX) begin
            rpdo_hold   <= rx_frame.data;
            rpdo_hold_v <= 1'b1;
        end else if (sync_evt) begin
            rpdo_hold_v <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpdo_data  <= 64'h0;
            rpdo_valid <= 1'b0;
        end else begin
            rpdo_valid <= 1'b0;
            if (rpdo_rx && rpdo_type >= TYPE_ASY_MIN) begin
                rpdo_data  <= rx_frame.data;
                rpdo_valid <= 1'b1;
            end else if (sync_evt && rpdo_hold_v) begin
                rpdo_data  <= rpdo_hold;
                rpdo_valid <= 1'b1;
            end
        end
    end

    // *************************************************************
    // Transmit PDO
    // *************************************************************
    logic [63:0] tpdo_img;
    logic [3:0]  tpdo_dlc;
    logic [63:0] last_img;
    logic        changed;
    logic [7:0]  sync_cnt;
    logic [23:0] inh_cnt;
    logic [25:0] evt_cnt;
    logic        trig;
    logic        tpdo_on;

    // Objects in mapping order, low byte first
    always_comb begin
        logic [3:0] off;
        off      = 4'h0;
        tpdo_img = 64'h0;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < map_cnt) begin
                for (int b = 0; b < 4; b++) begin
                    if (b < int'(map_ent[i][7:3]) && off < 4'h8) begin
                        tpdo_img[off*8 +: 8] = tpdo_obj[i][b*8 +: 8];
                        off = off + 4'h1;
                    end
                end
            end
        end
        tpdo_dlc = off;
    end

    assign tpdo_on = !tpdo_id[BIT_INVALID];
    assign changed = tpdo_img != last_img;

    always_comb begin
        trig = 1'b0;
        if (tpdo_type == 8'h00) begin
            trig = sync_evt && changed;
        end else if (tpdo_type <= TYPE_CYC_MAX) begin
            trig = sync_evt && sync_cnt + 8'h01 >= tpdo_type;
        end else if (tpdo_type >= TYPE_ASY_MIN) begin
            trig = changed || (tpdo_evt != 16'h0 && evt_cnt == 26'h0
                               && us_tick);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt <= 8'h00;
        end else if (sync_evt && tpdo_type != 8'h00
                     && tpdo_type <= TYPE_CYC_MAX) begin
            sync_cnt <= (sync_cnt + 8'h01 >= tpdo_type) ? 8'h00
                                                         : sync_cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tpdo_pend <= 1'b0;
        end else if (tpdo_on && trig) begin
            tpdo_pend <= 1'b1;
        end else if (!tpdo_on || (tx_done && tx_kind == K_TPDO)) begin
            tpdo_pend <= 1'b0;
        end
    end

    // Inhibit and event timers, both in microseconds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_cnt  <= 24'h0;
            evt_cnt  <= 26'h0;
        end else begin
            if (tx_done && tx_kind == K_TPDO) begin
                inh_cnt  <= 24'(tpdo_inh * INH_UNIT_US);
                evt_cnt  <= 26'(tpdo_evt * EVT_UNIT_US);
            end else if (us_tick) begin
                if (inh_cnt != 24'h0) begin
                    inh_cnt <= inh_cnt - 24'h1;
                end
                evt_cnt <= (evt_cnt == 26'h0) ? 26'(tpdo_evt * EVT_UNIT_US)
                                              : evt_cnt - 26'h1;
            end
        end
    end

    // *************************************************************
    // Faults and EMCY
    // *************************************************************
    logic [63:0] emcy_data;
    logic        emcy_pend;

    // Received EMCY frames match no decoder and are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg   <= 8'h00;
            err_code  <= 16'h0000;
            err_count <= 8'h00;
            emcy_data <= 64'h0;
            emcy_pend <= 1'b0;
        end else begin
            if (fault_valid) begin
                err_reg   <= fault.err_reg;
                err_code  <= fault.user ? ERR_USER : fault.code;
                err_count <= err_count + 8'h01;
                emcy_data <= {fault.user ? fault.aux : 32'h0,
                              8'h00, fault.err_reg,
                              fault.user ? ERR_USER : fault.code};
            end
            if (fault_valid && !emcy_id[BIT_INVALID]) begin
                emcy_pend <= 1'b1;
            end else if (tx_done && tx_kind == K_EMCY) begin
                emcy_pend <= 1'b0;
            end
        end
    end

    // *************************************************************
    // Transmit arbitration
    // *************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_frame <= '0;
            tx_kind  <= K_SYNC;
            last_img <= 64'h0;
        end else if (!tx_valid || tx_ready) begin
            tx_valid <= 1'b0;
            if (sync_due && !(tx_done && tx_kind == K_SYNC)) begin
                tx_valid <= 1'b1;
                tx_kind  <= K_SYNC;
                tx_frame <= '{id: sync_id[10:0], dlc: DLC_NONE,
                              data: 64'h0};
            end else if (emcy_pend && !(tx_done && tx_kind == K_EMCY)) begin
                tx_valid <= 1'b1;
                tx_kind  <= K_EMCY;
                tx_frame <= '{id: EMCY_BASE + 11'(node_id),
                              dlc: DLC_FULL, data: emcy_data};
            end else if (tpdo_pend && inh_cnt == 24'h0
                         && !(tx_done && tx_kind == K_TPDO)) begin
                tx_valid <= 1'b1;
                tx_kind  <= K_TPDO;
                tx_frame <= '{id: tpdo_id[10:0], dlc: tpdo_dlc,
                              data: tpdo_img};
                // Image taken at load, so a queued change fires only once
                last_img <= tpdo_img;
            end
        end
    end

    // *************************************************************
    // Checks
    // *************************************************************
    sync_rpdo_a: assert property (@(posedge pclk) disable iff (!presetn)
        rpdo_rx && rpdo_type <= TYPE_CYC_MAX && !sync_evt
        |=> !rpdo_valid) else $error("sync RPDO released early");
    async_rpdo_a: assert property (@(posedge pclk) disable iff (!presetn)
        rpdo_rx && rpdo_type >= TYPE_ASY_MIN
        |=> rpdo_valid && rpdo_data == $past(rx_frame.data))
        else $error("async RPDO not passed on");
    type0_send_a: assert property (@(posedge pclk) disable iff (!presetn)
        tpdo_on && tpdo_type == 8'h00 && sync_evt && changed
        |=> tpdo_pend) else $error("type 0 TPDO not queued");
    type0_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tpdo_pend && tpdo_type == 8'h00 && !sync_evt
        |=> !tpdo_pend) else $error("type 0 TPDO without SYNC");
    cyc_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        tpdo_type != 8'h00 && tpdo_type <= TYPE_CYC_MAX
        |-> sync_cnt < tpdo_type) else $error("SYNC count overran");
    async_send_a: assert property (@(posedge pclk) disable iff (!presetn)
        tpdo_on && tpdo_type >= TYPE_ASY_MIN && changed
        |=> tpdo_pend) else $error("changed data not queued");
    emcy_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_kind == K_EMCY |-> tx_frame.id
        == EMCY_BASE + 11'(node_id) && tx_frame.dlc == DLC_FULL)
        else $error("bad EMCY frame");
    emcy_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_valid && emcy_id[BIT_INVALID] && !emcy_pend
        |=> !emcy_pend && err_reg == $past(fault.err_reg))
        else $error("disabled EMCY queued");
    inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_valid) && tx_kind == K_TPDO |-> $past(inh_cnt) == 24'h0)
        else $error("TPDO sent within inhibit");
    invalid_a: assert property (@(posedge pclk) disable iff (!presetn)
        tpdo_id[BIT_INVALID] |=> !tpdo_pend)
        else $error("invalid TPDO pending");
endmodule

/* rtl/cpdo_pkg.sv */
// Package of constants and carriers for the PDO, SYNC and EMCY logic
package cpdo_pkg;
    // *************************************************************
    // Register offsets
    // *************************************************************
    localparam logic [7:0] OFS_NODE_ID   = 8'h00;
    localparam logic [7:0] OFS_SYNC_ID   = 8'h04;
    localparam logic [7:0] OFS_SYNC_PER  = 8'h08;
    localparam logic [7:0] OFS_EMCY_ID   = 8'h0c;
    localparam logic [7:0] OFS_TPDO_ID   = 8'h10;
    localparam logic [7:0] OFS_TPDO_TYPE = 8'h14;
    localparam logic [7:0] OFS_TPDO_INH  = 8'h18;
    localparam logic [7:0] OFS_TPDO_EVT  = 8'h1c;
    localparam logic [7:0] OFS_TPDO_MCNT = 8'h20;
    localparam logic [7:0] OFS_TPDO_MAP0 = 8'h24;
    localparam logic [7:0] OFS_RPDO_ID   = 8'h34;
    localparam logic [7:0] OFS_RPDO_TYPE = 8'h38;
    localparam logic [7:0] OFS_ERR_REG   = 8'h3c;
    localparam logic [7:0] OFS_ERR_FIELD = 8'h40;
    localparam logic [7:0] OFS_STATUS    = 8'h44;
    // *************************************************************
    // Field positions and reset values
    // *************************************************************
    localparam int          BIT_INVALID   = 31;
    localparam int          BIT_SYNC_GEN  = 30;
    localparam logic [31:0] RST_SYNC_ID   = 32'h0000_0080;
    localparam logic [31:0] RST_EMCY_ID   = 32'h8000_0080;
    localparam logic [31:0] RST_TPDO_ID   = 32'h8000_0180;
    localparam logic [31:0] RST_RPDO_ID   = 32'h8000_0200;
    localparam logic [10:0] EMCY_BASE     = 11'h080;
    localparam logic [15:0] ERR_USER      = 16'hff00;
    localparam logic [7:0]  TYPE_CYC_MAX  = 8'hf0;
    localparam logic [7:0]  TYPE_ASY_MIN  = 8'hfe;
    localparam logic [6:0]  MAX_BITS      = 7'h40;
    localparam logic [3:0]  DLC_FULL      = 4'h8;
    localparam logic [3:0]  DLC_NONE      = 4'h0;
    // *************************************************************
    // Timing
    // *************************************************************
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          US_NS         = 1000;
    localparam int          US_CYC        = US_NS / CLK_PERIOD_NS;
    localparam int          INH_UNIT_US   = 125;
    localparam int          EVT_UNIT_US   = 1000;
    // *************************************************************
    // Carriers
    // *************************************************************
    typedef struct packed {
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cpdo_frame_s;
    typedef struct packed {
        logic [15:0] code;
        logic [7:0]  err_reg;
        logic        user;
        logic [31:0] aux;
    } cpdo_fault_s;
    typedef enum logic [1:0] {K_SYNC, K_EMCY, K_TPDO} cpdo_kind_e;
endpackage

/* tb/canopen_pdo_sync_emcy_logic_tb_top.sv */
// Self-checking bench of the PDO, SYNC and EMCY logic
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module canopen_pdo_sync_emcy_logic_tb_top import cpdo_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, ax;
    logic pready, pslverr, e, rx_valid, tx_valid, tx_ready, rpdo_valid;
    logic sync_pulse, fault_valid = 0;
    logic [7:0] er;
    logic [63:0] rpdo_data, rp, d;
    logic [3:0][31:0] obj = '0;
    cpdo_frame_s rx_frame, tx_frame;
    cpdo_fault_s fault = '0;
    int failures = 0, n_tests = 0, n_rp = 0, n_sp = 0, n0;
    always #10 pclk = ~pclk;
    cpdo_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
        .tx_frame(tx_frame), .tx_ready(tx_ready), .tpdo_obj(obj),
        .rpdo_data(rpdo_data), .rpdo_valid(rpdo_valid),
        .sync_pulse(sync_pulse), .fault_valid(fault_valid), .fault(fault));
    cpdo_master_model m (.pclk(pclk), .slow(slow), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready));
    always @(posedge pclk) if (sync_pulse === 1'b1) n_sp <= n_sp + 1;
    always @(posedge pclk) if (rpdo_valid === 1'b1) begin
        n_rp <= n_rp + 1;
        rp <= rpdo_data;
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic flt(input logic u, input logic [15:0] c);
        er = 8'($urandom);
        ax = $urandom;
        @(posedge pclk);
        fault <= '{c, er, u, ax};
        fault_valid <= 1'b1;
        @(posedge pclk);
        fault_valid <= 1'b0;
        idle(8);
    endtask
    function automatic logic [63:0] emcy(input logic u, input logic [15:0] c);
        return {u ? ax : 32'h0, 8'h00, er, u ? ERR_USER : c};
    endfunction
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(32'he052c7ae));
        idle(12);
        presetn <= 1'b1;
        apb(0, OFS_SYNC_ID, 0);
        `CHK("sync id", RST_SYNC_ID, r)
        apb(0, OFS_EMCY_ID, 0);
        `CHK("emcy id", RST_EMCY_ID, r)
        apb(0, 8'hfc, 0);
        `CHK("unmapped err", 1'b1, e)
        apb(1, OFS_NODE_ID, 1);
        flt(0, 16'h8130);
        `CHK("emcy off", 0, m.n_rx)
        apb(0, OFS_ERR_REG, 0);
        `CHK("err reg", er, r[7:0])
        apb(1, OFS_EMCY_ID, 32'h0000_0081);
        slow <= 1'b1;
        flt(1, 16'h1234);
        `CHK("emcy id", 11'h081, m.last.id)
        `CHK("emcy user", emcy(1, 0), m.last.data)
        flt(0, 16'h8130);
        `CHK("emcy comm", emcy(0, 16'h8130), m.last.data)
        $display("emcy test done");
        apb(1, OFS_RPDO_ID, 32'h201);
        apb(1, OFS_RPDO_TYPE, 255);
        d = {$urandom, $urandom};
        m.send(11'h201, d);
        idle(2);
        `CHK("async rpdo", d, rp)
        apb(1, OFS_RPDO_TYPE, 0);
        n0 = n_rp;
        m.send(11'h201, ~d);
        m.send(11'h201, d + 1);
        m.send(11'h082, ~d);
        idle(3);
        `CHK("rpdo held", n0, n_rp)
        m.send(11'h080, 0);
        idle(3);
        `CHK("rpdo on sync", d + 1, rp)
        apb(1, OFS_RPDO_ID, 32'h8000_0201);
        m.send(11'h080, 0);
        m.send(11'h201, d);
        idle(3);
        `CHK("rpdo invalid", n0 + 1, n_rp)
        $display("rpdo test done");
        apb(1, OFS_TPDO_MCNT, 5);
        `CHK("map count", 1'b1, e)
        apb(1, OFS_TPDO_MAP0, 32'h6041_000c);
        `CHK("map len", 1'b1, e)
        apb(1, OFS_TPDO_ID, 32'h181);
        apb(1, OFS_TPDO_MAP0, 32'h6041_0010);
        apb(1, OFS_TPDO_MCNT, 1);
        apb(1, OFS_TPDO_MAP0 + 8'h04, 32'h6064_0020);
        apb(1, OFS_TPDO_MAP0 + 8'h08, 32'h6064_0020);
        apb(1, OFS_TPDO_MCNT, 3);
        `CHK("map total", 1'b1, e)
        apb(1, OFS_TPDO_TYPE, 0);
        obj[0] <= {16'h0, 16'($urandom) | 16'h1};
        m.send(11'h080, 0);
        idle(8);
        `CHK("tpdo frame", {11'h181, 4'h2, 48'h0, obj[0][15:0]}, m.last)
        n0 = m.n_rx;
        m.send(11'h080, 0);
        idle(8);
        `CHK("tpdo same", n0, m.n_rx)
        apb(1, OFS_TPDO_TYPE, 2);
        repeat (4) m.send(11'h080, 0);
        idle(8);
        `CHK("tpdo cyclic", n0 + 2, m.n_rx)
        apb(1, OFS_TPDO_TYPE, 255);
        obj[0] <= obj[0] ^ 32'h5a;
        idle(10);
        `CHK("tpdo async", n0 + 3, m.n_rx)
        $display("tpdo test done");
        n0 = n_sp;
        apb(1, OFS_SYNC_PER, 2);
        apb(1, OFS_SYNC_ID, 32'h4000_0080);
        idle(250);
        `CHK("sync frame", {11'h080, DLC_NONE, 64'h0}, m.last)
        `CHK("sync made", 1'b1, n_sp > n0)
        $display("sync test done");
        close_out();
    end
endmodule

/* tb/cpdo_master_model.sv */
// Network master model on the CAN side of the block
`timescale 1ns/10ps
module cpdo_master_model import cpdo_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        slow,
    output logic             rx_valid,
    output cpdo_frame_s      rx_frame,
    input  wire logic        tx_valid,
    input  wire cpdo_frame_s tx_frame,
    output logic             tx_ready
);
    cpdo_frame_s last = '0;
    int          n_rx = 0;
    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
        tx_ready = 1'b0;
    end
    // Commands first, SYNC after, as the bench orders the calls in the held RPDO check; the invalid RPDO check sends SYNC first
    task automatic send(input logic [10:0] id, input logic [63:0] d);
        @(posedge pclk);
        rx_frame <= '{id, DLC_FULL, d};
        rx_valid <= 1'b1;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame;
    endtask
    always @(posedge pclk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            last <= tx_frame;
            n_rx <= n_rx + 1;
        end
    end
endmodule
